// >>> dv/lsup_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module lsup_chk (
    input wire        aclk,
    input wire        aresetn,
    input wire [31:0] trip_count,
    input wire [31:0] hour_count,
    input wire [33:0] now_date,
    input wire        oil_empty,
    input wire        out_of_order,
    input wire        maint_ind,
    input wire [2:0]  maint_which,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_err_ooo: assert property (oil_empty == out_of_order)
        else $error("empty flag and out of order differ");
    a_maint_any: assert property (maint_ind == (|maint_which))
        else $error("maintenance output disagrees with interval flags");
    a_trip_max: assert property ($stable(trip_count) && &trip_count |=> maint_which[0])
        else $error("trip interval missed at full count");
    a_hour_zero: assert property ($stable(hour_count) && hour_count == 32'h0 |=> !maint_which[1])
        else $error("hour interval raised at zero hours");
    a_date_zero: assert property ($stable(now_date) && now_date == 34'h0 |=> !maint_which[2])
        else $error("date interval raised at zero date");
    a_wr_resp: assert property (s_wr_take ##0 !s_axi_bvalid |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_rd_resp: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read data late");
    a_wr_block: assert property (s_wr_take |=> !s_axi_awready && !s_axi_wready)
        else $error("second write accepted before the first completed");
    a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
endmodule
bind lsup_top lsup_chk u_chk (.aclk, .aresetn, .trip_count, .hour_count, .now_date,
    .oil_empty, .out_of_order, .maint_ind, .maint_which, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

// >>> dv/lsup_plant.sv
`timescale 1ns/10ps
`default_nettype none
module lsup_plant (
    input  wire         aclk,
    input  wire  [15:0] spd_req,
    input  wire         pump_req,
    output logic [15:0] car_speed,
    output logic        pump_on
);
    initial begin
        car_speed = 16'h0000;
        pump_on = 1'b0;
    end
    // speed sensor refreshes once a clock; pump contact has no clock relation
    always @(posedge aclk) car_speed <= spd_req;
    always @(pump_req) pump_on <= #7 pump_req;
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "lsup_regs.vh"
module tb_top;
    logic aclk, aresetn = 0, pump_req = 0, s_axi_bready = 1, s_axi_rready = 1;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [3:0] s_axi_wstrb = 4'hf, vexp = 0;
    logic [15:0] spd_req = 0;
    logic [31:0] trip_count = 0, hour_count = 0, s_axi_wdata = 0, tl = 32'hffff_ffff, hl;
    logic [33:0] now_date = 0, dl = `LSUP_DATE_LIM_RST;
    wire [15:0] car_speed;
    wire [31:0] s_axi_rdata;
    wire [3:0] vel_thr_out;
    wire [2:0] maint_which;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire pump_on, oil_warn, oil_empty, out_of_order, maint_ind;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int err_total = 0, check_count = 0, vth[4], off[5] = '{-1, 15, 16, 8, 0};
    lsup_plant u_plant (.aclk, .spd_req, .pump_req, .car_speed, .pump_on);
    lsup_top dut (.aclk, .aresetn, .car_speed, .pump_on, .trip_count, .hour_count, .now_date,
        .vel_thr_out, .oil_warn, .oil_empty, .out_of_order, .maint_ind, .maint_which,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    initial begin
        aclk = 0;
        forever #20 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // handshakes are judged at the rising edge, before that edge's design updates land
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        chk(s_axi_bresp, er);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rresp, er);
        if (er == 2'b00) chk(s_axi_rdata, e);
    endtask
    task automatic spd(input int v);
        spd_req <= v[15:0];
        repeat (4) @(posedge aclk);
        for (int i = 0; i < 4; i++) begin
            if (v < vth[i]) vexp[i] = 1;
            else if (v > vth[i] + 15) vexp[i] = 0;
        end
        chk(vel_thr_out, vexp);
    endtask
    task automatic mc(input logic [31:0] t, input logic [31:0] h, input logic [33:0] d);
        logic [2:0] e;
        trip_count <= t;
        hour_count <= h;
        now_date <= d;
        repeat (3) @(posedge aclk);
        e = {dl != `LSUP_DATE_OFF && d > dl, h > hl, t >= tl};
        chk(maint_which, e);
        chk(maint_ind, |e);
    endtask
    task tally_and_finish;
        if (err_total == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(48388));
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(`LSUP_OIL_WARN, `LSUP_OIL_WARN_RST, 0);
        rd(`LSUP_OIL_ERR, `LSUP_OIL_ERR_RST, 0);
        rd(`LSUP_HOUR_LIM, `LSUP_HOUR_LIM_RST, 0);
        rd(8'h40, 0, 2'b10);
        wr(8'h40, 1, 2'b10);
        hl = `LSUP_HOUR_LIM_RST;
        mc(7, 9, 34'h3_ffff_ffff);
        for (int i = 0; i < 4; i++) begin
            vth[i] = 100 + 200 * i + $urandom % 50;
            wr(`LSUP_VTH0 + 8'(4 * i), vth[i], 0);
        end
        foreach (vth[i]) foreach (off[j]) spd(vth[i] + off[j]);
        repeat (20) spd($urandom % 900);
        wr(`LSUP_OIL_WARN, 0, 0);
        wr(`LSUP_OIL_ERR, 0, 0);
        repeat (2) @(posedge aclk);
        chk({oil_warn, oil_empty, out_of_order}, 3'b111);
        pump_req <= 1;
        repeat (40) @(posedge aclk);
        rd(`LSUP_PUMP_RUN, 0, 0);
        wr(`LSUP_CTRL, 1, 0);
        pump_req <= 0;
        rd(`LSUP_PUMP_RUN, 0, 0);
        wr(`LSUP_OIL_ERR, `LSUP_OIL_ERR_RST, 0);
        wr(`LSUP_OIL_WARN, 32'h0000_00ff, 0);
        repeat (2) @(posedge aclk);
        chk({oil_warn, oil_empty, out_of_order}, 3'b000);
        s_axi_wstrb <= 4'h2;
        wr(`LSUP_OIL_WARN, 32'h1234_5678, 0);
        s_axi_wstrb <= 4'hf;
        rd(`LSUP_OIL_WARN, 32'h0000_56ff, 0);
        tl = 10 + $urandom % 5;
        hl = 20;
        dl[31:0] = 32'h0000_1000;
        wr(`LSUP_TRIP_LIM, tl, 0);
        wr(`LSUP_HOUR_LIM, hl, 0);
        wr(`LSUP_DATE_LIM, dl[31:0], 0);
        mc(tl - 1, hl, dl);
        mc(tl, hl + 1, dl + 1);
        rd(`LSUP_STATUS, (32'h1 << `LSUP_ST_MAINT) | (32'h7 << `LSUP_ST_MT_TRIP) | {28'h0, vexp}, 0);
        mc(0, 0, 0);
        mc(32'hffff_ffff, 0, 0);
        tally_and_finish;
    end
endmodule
`default_nettype wire

// >>> src/lsup_regs.vh
`ifndef LSUP_REGS_VH
`define LSUP_REGS_VH
// register byte offsets
`define LSUP_CTRL          8'h00
`define LSUP_STATUS        8'h04
`define LSUP_PUMP_RUN      8'h08
`define LSUP_OIL_WARN      8'h0c
`define LSUP_OIL_ERR       8'h10
`define LSUP_TRIP_LIM      8'h14
`define LSUP_HOUR_LIM      8'h18
`define LSUP_DATE_LIM      8'h1c
`define LSUP_VTH0          8'h20
`define LSUP_VTH1          8'h24
`define LSUP_VTH2          8'h28
`define LSUP_VTH3          8'h2c
// ctrl fields (write one to act, self clearing)
`define LSUP_CTRL_PUMP_CLR 0
// status fields
`define LSUP_ST_VEL_LSB    0
`define LSUP_ST_WARN       4
`define LSUP_ST_ERR        5
`define LSUP_ST_MT_TRIP    6
`define LSUP_ST_MT_HOUR    7
`define LSUP_ST_MT_DATE    8
`define LSUP_ST_MAINT      9
`define LSUP_ST_OOO        10
// reset values
`define LSUP_OIL_WARN_RST  32'h0000_ffff
`define LSUP_OIL_ERR_RST   32'hffff_ffff
`define LSUP_TRIP_LIM_RST  32'hffff_ffff
`define LSUP_HOUR_LIM_RST  32'hffff_ffff
`define LSUP_VTH_RST       16'h0000
// date packed as yyyy(14) mm(4) dd(5) hh(5) mi(6): 01.01.2999 00:00 disables
`define LSUP_DATE_OFF      34'h0_bb71_0800
`define LSUP_DATE_LIM_RST  34'h0_bb71_0800
// timing
`define LSUP_CLK_HZ        25000000
`define LSUP_HYST_MMS      16'h000f
`endif

// >>> src/lsup_top.v
`timescale 1ns/10ps
`default_nettype none
`include "lsup_regs.vh"

// What this block does
// - output on when speed below threshold
// - 15 mm/s hysteresis band on switching
// - four thresholds, each own indexed output
// - accumulate oil pump engaged time
// - warning when runtime reaches warn limit
// - error and out of order at limit
// - runtime readable, cleared by maintenance command
// - maintenance when trips reach trip limit
// - maintenance when hours exceed hour limit
// - maintenance when date passes set date
// - date 01.01.2999 disables date interval
// - report interval on output, status, which
module lsup_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [15:0] car_speed,
    input  wire        pump_on,
    input  wire [31:0] trip_count,
    input  wire [31:0] hour_count,
    input  wire [33:0] now_date,
    output reg  [3:0]  vel_thr_out,
    output reg         oil_warn,
    output reg         oil_empty,
    output reg         out_of_order,
    output reg         maint_ind,
    output reg  [2:0]  maint_which,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);
    localparam integer SEC_TICKS = `LSUP_CLK_HZ;

    reg  [2:0]  pump_sync_q;
    reg         pump_q;
    reg  [24:0] sec_div_q;
    reg  [31:0] run_q;
    reg  [31:0] warn_lim_q;
    reg  [31:0] err_lim_q;
    reg  [31:0] trip_lim_q;
    reg  [31:0] hour_lim_q;
    reg  [33:0] date_lim_q;
    reg  [15:0] vth_q [0:3];
    reg  [7:0]  aw_addr_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;
    reg         aw_full_q;
    reg         w_full_q;
    wire        wr_go;
    wire        aw_take;
    wire        w_take;
    wire        b_done;
    wire        ar_take;
    wire        sec_tick;
    wire        run_at_warn;
    wire        run_at_err;
    wire        mt_trip;
    wire        mt_hour;
    wire        mt_date;
    wire [31:0] vth_wr;
    wire [31:0] status_word;
    integer     i;
    integer     k;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  be;
        integer      b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (be[b]) begin
                    merge[b*8 +: 8] = nw[b*8 +: 8];
                end
            end
        end
    endfunction

    // word aligned register offset, shared by both channels
    function [7:0] word_of;
        input [7:0] addr;
        begin
            word_of = {addr[7:2], 2'b00};
        end
    endfunction

    // pump indication comes from a pin; accept a change once stages two and three agree
    always @(posedge aclk) begin
        if (!aresetn) begin
            pump_sync_q <= 3'h0;
            pump_q      <= 1'b0;
        end else begin
            pump_sync_q <= {pump_sync_q[1:0], pump_on};
            if (pump_sync_q[1] == pump_sync_q[2]) begin
                pump_q <= pump_sync_q[2];
            end
        end
    end

    // one second enable, counting only while the pump runs so partial seconds carry over
    assign sec_tick = pump_q && (sec_div_q == SEC_TICKS[24:0] - 25'h1);

    always @(posedge aclk) begin
        if (!aresetn) begin
            sec_div_q <= 25'h0;
        end else if (pump_q) begin
            sec_div_q <= sec_tick ? 25'h0 : sec_div_q + 25'h1;
        end
    end

    // velocity comparators with hysteresis
    always @(posedge aclk) begin
        if (!aresetn) begin
            vel_thr_out <= 4'h0;
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                if (car_speed < vth_q[i]) begin
                    vel_thr_out[i] <= 1'b1;
                end else if ({1'b0, car_speed} > {1'b0, vth_q[i]} + {1'b0, `LSUP_HYST_MMS}) begin
                    vel_thr_out[i] <= 1'b0;
                end
            end
        end
    end

    // out of order follows the empty flag; only a runtime clear or a higher limit lifts it
    assign run_at_warn = run_q >= warn_lim_q;
    assign run_at_err  = run_q >= err_lim_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            oil_warn     <= 1'b0;
            oil_empty    <= 1'b0;
            out_of_order <= 1'b0;
        end else begin
            oil_warn     <= run_at_warn;
            oil_empty    <= run_at_err;
            out_of_order <= run_at_err;
        end
    end

    // maintenance comparators
    assign mt_trip = trip_count >= trip_lim_q;
    assign mt_hour = hour_count > hour_lim_q;
    assign mt_date = (date_lim_q != `LSUP_DATE_OFF) && (now_date > date_lim_q);

    always @(posedge aclk) begin
        if (!aresetn) begin
            maint_ind   <= 1'b0;
            maint_which <= 3'h0;
        end else begin
            maint_ind   <= mt_trip | mt_hour | mt_date;
            maint_which <= {mt_date, mt_hour, mt_trip};
        end
    end

    // axi4-lite write: address and data taken in either order, each held until both arrive
    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready  = !w_full_q;
    assign wr_go         = aw_full_q && w_full_q && !s_axi_bvalid;
    assign aw_take       = s_axi_awvalid && !aw_full_q;
    assign w_take        = s_axi_wvalid && !w_full_q;
    assign b_done        = s_axi_bvalid && s_axi_bready;
    assign vth_wr        = merge({16'h0, vth_q[aw_addr_q[3:2]]}, w_data_q, w_strb_q);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q    <= 1'b0;
            w_full_q     <= 1'b0;
            aw_addr_q    <= 8'h00;
            w_data_q     <= 32'h0;
            w_strb_q     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
            run_q        <= 32'h0;
            warn_lim_q   <= `LSUP_OIL_WARN_RST;
            err_lim_q    <= `LSUP_OIL_ERR_RST;
            trip_lim_q   <= `LSUP_TRIP_LIM_RST;
            hour_lim_q   <= `LSUP_HOUR_LIM_RST;
            date_lim_q   <= `LSUP_DATE_LIM_RST;
            for (k = 0; k < 4; k = k + 1) begin
                vth_q[k] <= `LSUP_VTH_RST;
            end
        end else begin
            if (aw_take) begin
                aw_addr_q <= s_axi_awaddr;
                aw_full_q <= 1'b1;
            end
            if (w_take) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                w_full_q <= 1'b1;
            end
            if (b_done) begin
                s_axi_bvalid <= 1'b0;
            end
            // a tick in the same cycle as a clear loses one second; clear is a deliberate refill
            if (sec_tick && run_q != 32'hffff_ffff) begin
                run_q <= run_q + 32'h1;
            end
            if (wr_go) begin
                aw_full_q    <= 1'b0;
                w_full_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'h0;
                case (word_of(aw_addr_q))
                    `LSUP_CTRL: begin
                        if (w_strb_q[0] && w_data_q[`LSUP_CTRL_PUMP_CLR]) begin
                            run_q <= 32'h0;
                        end
                    end
                    `LSUP_OIL_WARN: begin
                        warn_lim_q <= merge(warn_lim_q, w_data_q, w_strb_q);
                    end
                    `LSUP_OIL_ERR: begin
                        err_lim_q <= merge(err_lim_q, w_data_q, w_strb_q);
                    end
                    `LSUP_TRIP_LIM: begin
                        trip_lim_q <= merge(trip_lim_q, w_data_q, w_strb_q);
                    end
                    `LSUP_HOUR_LIM: begin
                        hour_lim_q <= merge(hour_lim_q, w_data_q, w_strb_q);
                    end
                    `LSUP_DATE_LIM: begin
                        // the top two year bits keep their reset value: the bus word is 32 bits
                        date_lim_q <= {date_lim_q[33:32], 32'h0} |
                                      {2'b00, merge(date_lim_q[31:0], w_data_q, w_strb_q)};
                    end
                    `LSUP_VTH0, `LSUP_VTH1, `LSUP_VTH2, `LSUP_VTH3: begin
                        vth_q[aw_addr_q[3:2]] <= vth_wr[15:0];
                    end
                    default: begin
                        s_axi_bresp <= 2'h2;
                    end
                endcase
            end
        end
    end

    // read channel: one cycle answer, unmapped gives slverr
    assign s_axi_arready = !s_axi_rvalid;
    assign ar_take       = s_axi_arvalid && !s_axi_rvalid;
    assign status_word   = {21'h0, out_of_order, maint_ind, maint_which,
                            oil_empty, oil_warn, vel_thr_out};

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= 2'h0;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            s_axi_rdata  <= 32'h0;
            case (word_of(s_axi_araddr))
                `LSUP_CTRL: begin
                    s_axi_rdata <= 32'h0;
                end
                `LSUP_STATUS: begin
                    s_axi_rdata <= status_word;
                end
                `LSUP_PUMP_RUN: begin
                    s_axi_rdata <= run_q;
                end
                `LSUP_OIL_WARN: begin
                    s_axi_rdata <= warn_lim_q;
                end
                `LSUP_OIL_ERR: begin
                    s_axi_rdata <= err_lim_q;
                end
                `LSUP_TRIP_LIM: begin
                    s_axi_rdata <= trip_lim_q;
                end
                `LSUP_HOUR_LIM: begin
                    s_axi_rdata <= hour_lim_q;
                end
                `LSUP_DATE_LIM: begin
                    s_axi_rdata <= date_lim_q[31:0];
                end
                `LSUP_VTH0, `LSUP_VTH1, `LSUP_VTH2, `LSUP_VTH3: begin
                    s_axi_rdata <= {16'h0, vth_q[s_axi_araddr[3:2]]};
                end
                default: begin
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end
    end
endmodule
`default_nettype wire
